// *** core/io_port_bit_mapper.sv ***
// multi-function port pin mapper with its control-port register access
module io_port_bit_mapper #(
    parameter int NUM_PINS = io_port_bit_mapper_pkg::NUM_PINS
) (
    input  wire logic                                      clk,
    input  wire logic                                      rst,
    input  wire logic                                      port_strobe,
    input  wire logic                                      port_function_select,
    input  wire logic                                      port_read_write,
    input  wire logic [io_port_bit_mapper_pkg::BUS_W-1:0]  port_bus_in,
    input  wire logic [NUM_PINS-1:0]                       io_pin_in,
    input  wire logic [io_port_bit_mapper_pkg::STAT_N-1:0] status_bits,
    input  wire logic [io_port_bit_mapper_pkg::CTRL_N-1:0] ctrl_reg_value,
    output logic      [NUM_PINS-1:0]                       io_pin_out,
    output logic      [NUM_PINS-1:0]                       io_pin_oe_n,
    output logic      [io_port_bit_mapper_pkg::CTRL_N-1:0] control_bits,
    output logic      [io_port_bit_mapper_pkg::CTRL_N-1:0] control_override
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_PINS != io_port_bit_mapper_pkg::NUM_PINS)
    begin : g_chk
        $error("pin count must match the register block address range");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    io_port_bit_mapper_pkg::port_in_t port_raw;
    io_port_bit_mapper_pkg::port_in_t port_s;
    logic [NUM_PINS-1:0]              pin_s;

    always_comb
    begin
        port_raw.strobe     = port_strobe;
        port_raw.func_sel   = port_function_select;
        port_raw.read_write = port_read_write;
        port_raw.bus        = port_bus_in;
    end

    // bus and strobe share the same delay, so data is settled at the edge
    port_sync #(
        .W (io_port_bit_mapper_pkg::PORT_IN_W)
    ) u_port_sync (
        .clk (clk),
        .rst (rst),
        .d   (port_raw),
        .q   (port_s)
    );

    port_sync #(
        .W (NUM_PINS)
    ) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .d   (io_pin_in),
        .q   (pin_s)
    );

    // ------------------------------------------------------------
    // strobe edge and two-phase write sequencer
    // ------------------------------------------------------------
    logic                                     strobe_d_r;
    logic                                     strobe_d_nxt;
    io_port_bit_mapper_pkg::phase_t           phase_r;
    io_port_bit_mapper_pkg::phase_t           phase_nxt;
    logic [io_port_bit_mapper_pkg::BUS_W-1:0] addr_r;
    logic [io_port_bit_mapper_pkg::BUS_W-1:0] addr_nxt;
    logic                                     strobe_rise;
    logic                                     ctrl_write;
    logic                                     wr_fire;
    logic                                     addr_hit;
    logic [io_port_bit_mapper_pkg::IDX_W-1:0] wr_idx;
    logic [io_port_bit_mapper_pkg::BUS_W-1:0] addr_off;

    always_comb
    begin
        strobe_d_nxt = port_s.strobe;
        strobe_rise  = port_s.strobe && !strobe_d_r;
        ctrl_write   = !port_s.func_sel && !port_s.read_write;
        addr_hit     = (addr_r >= io_port_bit_mapper_pkg::ADDR_PIN_FIRST)
                    && (addr_r <= io_port_bit_mapper_pkg::ADDR_PIN_LAST);
        addr_off     = addr_r - io_port_bit_mapper_pkg::ADDR_PIN_FIRST;
        wr_idx       = addr_off[io_port_bit_mapper_pkg::IDX_W-1:0];
        wr_fire      = 1'b0;
        phase_nxt    = phase_r;
        addr_nxt     = addr_r;
        if (strobe_rise)
        begin
            // ancillary or read strobes restart the write sequence
            if (!ctrl_write)
            begin
                phase_nxt = io_port_bit_mapper_pkg::PH_ADDR;
            end
            else
            begin
                case (phase_r)
                    io_port_bit_mapper_pkg::PH_ADDR:
                    begin
                        addr_nxt  = port_s.bus;
                        phase_nxt = io_port_bit_mapper_pkg::PH_DATA;
                    end
                    io_port_bit_mapper_pkg::PH_DATA:
                    begin
                        wr_fire   = addr_hit;
                        phase_nxt = io_port_bit_mapper_pkg::PH_ADDR;
                    end
                    default:
                    begin
                        phase_nxt = io_port_bit_mapper_pkg::PH_ADDR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strobe_d_r <= 1'b0;
            phase_r    <= io_port_bit_mapper_pkg::PH_ADDR;
            addr_r     <= '0;
        end
        else
        begin
            strobe_d_r <= strobe_d_nxt;
            phase_r    <= phase_nxt;
            addr_r     <= addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin-mapping registers
    // ------------------------------------------------------------
    io_port_bit_mapper_pkg::pin_cfg_t [NUM_PINS-1:0] cfg_r;
    io_port_bit_mapper_pkg::pin_cfg_t [NUM_PINS-1:0] cfg_nxt;

    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_fire)
        begin
            // upper bus bits carry no function and are dropped
            cfg_nxt[wr_idx] = port_s.bus[io_port_bit_mapper_pkg::CODE_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_r <= io_port_bit_mapper_pkg::RST_ALL;
        end
        else
        begin
            cfg_r <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_out_nxt;
    logic [NUM_PINS-1:0] pin_oe_n_nxt;
    logic [NUM_PINS-1:0] pin_out_r;
    logic [NUM_PINS-1:0] pin_oe_n_r;

    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        always_comb
        begin
            pin_oe_n_nxt[i] = cfg_r[i].input_dir;
            // reserved output codes drive a quiet low
            pin_out_nxt[i]  = !cfg_r[i].input_dir
                           && io_port_bit_mapper_pkg::OUT_VALID[cfg_r[i].sel]
                           && status_bits[cfg_r[i].sel];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_out_r  <= '0;
            pin_oe_n_r <= '1;
        end
        else
        begin
            pin_out_r  <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // control bit override from input pins
    // ------------------------------------------------------------
    logic [io_port_bit_mapper_pkg::CTRL_N-1:0] ctrl_nxt;
    logic [io_port_bit_mapper_pkg::CTRL_N-1:0] ovr_nxt;
    logic [io_port_bit_mapper_pkg::CTRL_N-1:0] ctrl_r;
    logic [io_port_bit_mapper_pkg::CTRL_N-1:0] ovr_r;

    // higher pin wins when two pins name the same control bit
    always_comb
    begin
        ctrl_nxt = ctrl_reg_value;
        ovr_nxt  = '0;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (cfg_r[i].input_dir && !cfg_r[i].sel[io_port_bit_mapper_pkg::GRP_BIT]
                && io_port_bit_mapper_pkg::IN_VALID[
                       cfg_r[i].sel[io_port_bit_mapper_pkg::CTRL_W-1:0]])
            begin
                ovr_nxt[cfg_r[i].sel[io_port_bit_mapper_pkg::CTRL_W-1:0]]  = 1'b1;
                ctrl_nxt[cfg_r[i].sel[io_port_bit_mapper_pkg::CTRL_W-1:0]] = pin_s[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r <= '0;
            ovr_r  <= '0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            ovr_r  <= ovr_nxt;
        end
    end

    assign io_pin_out       = pin_out_r;
    assign io_pin_oe_n      = pin_oe_n_r;
    assign control_bits     = ctrl_r;
    assign control_override = ovr_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_reset_codes;
        rst |=> cfg_r == io_port_bit_mapper_pkg::RST_ALL;
    endproperty
    a_reset_codes: assert property (disable iff (1'b0) p_reset_codes)
        else $error("pin codes not at power-on values after reset");

    property p_addr_capture;
        strobe_rise && ctrl_write && phase_r == io_port_bit_mapper_pkg::PH_ADDR
        |=> addr_r == $past(port_s.bus) && phase_r == io_port_bit_mapper_pkg::PH_DATA;
    endproperty
    a_addr_capture: assert property (p_addr_capture)
        else $error("address phase strobe did not capture the bus");

    property p_data_write;
        wr_fire |=> cfg_r[$past(wr_idx)]
                    == $past(port_s.bus[io_port_bit_mapper_pkg::CODE_W-1:0]);
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("data phase strobe did not write the register");

    property p_out_of_range;
        strobe_rise && ctrl_write && phase_r == io_port_bit_mapper_pkg::PH_DATA
        && !addr_hit |=> $stable(cfg_r);
    endproperty
    a_out_of_range: assert property (p_out_of_range)
        else $error("write outside pin-mapping range changed a register");

    property p_direction;
        // the enable register still holds its reset level one edge after release
        !$past(rst) |-> io_pin_oe_n[0] == $past(cfg_r[0].input_dir)
                     && io_pin_oe_n[7] == $past(cfg_r[7].input_dir);
    endproperty
    a_direction: assert property (p_direction)
        else $error("pin enable does not follow direction bit");

    property p_select;
        !cfg_r[0].input_dir && $stable(cfg_r) && $stable(status_bits)
        |=> io_pin_out[0] == (io_port_bit_mapper_pkg::OUT_VALID[$past(cfg_r[0].sel)]
                              && $past(status_bits[cfg_r[0].sel]));
    endproperty
    a_select: assert property (p_select)
        else $error("output pin does not carry its selected status bit");

    property p_reserved;
        cfg_r[7] == 6'h00 || cfg_r[7] == 6'h05 || cfg_r[7] == 6'h06
        || cfg_r[7] == 6'h0A || cfg_r[7] == 6'h0B || cfg_r[7] == 6'h0C |=> !io_pin_out[7];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved output code drove a high level");

    property p_override;
        cfg_r[7] == 6'h20 |=> control_bits[0] == $past(pin_s[7]) && control_override[0];
    endproperty
    a_override: assert property (p_override)
        else $error("input pin did not override its control bit");

    property p_no_override;
        ovr_nxt == '0 |=> control_bits == $past(ctrl_reg_value) && control_override == '0;
    endproperty
    a_no_override: assert property (p_no_override)
        else $error("control bits changed without a mapped input pin");

    c_write: cover property (strobe_rise && ctrl_write ##[1:40] wr_fire);
    c_input_pin: cover property (control_override != '0);
    c_remap: cover property (wr_fire ##1 !cfg_r[0].input_dir ##1 io_pin_out[0]);

endmodule // io_port_bit_mapper

// *** core/io_port_bit_mapper_pkg.sv ***
// constants and types of the multi-function port pin mapper
package io_port_bit_mapper_pkg;

    // ------------------------------------------------------------
    // port bus and pin geometry
    // ------------------------------------------------------------
    localparam int BUS_W    = 10;
    localparam int NUM_PINS = 8;
    localparam int CODE_W   = 6;
    localparam int SEL_W    = 5;
    localparam int IDX_W    = 3;
    localparam int STAT_N   = 32;
    localparam int CTRL_N   = 16;
    localparam int CTRL_W   = 4;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [BUS_W-1:0] ADDR_PIN_FIRST = 10'h00F;
    localparam logic [BUS_W-1:0] ADDR_PIN_LAST  = 10'h016;

    // ------------------------------------------------------------
    // function code layout
    // ------------------------------------------------------------
    localparam int DIR_BIT = 5;
    localparam int GRP_BIT = 4;

    // valid output codes 01h-1Fh minus reserved 05h,06h,0Ah-0Ch
    localparam logic [STAT_N-1:0] OUT_VALID = 32'hFFFF_E39E;
    // valid input codes 20h-2Fh minus reserved 29h-2Bh, by low nibble
    localparam logic [CTRL_N-1:0] IN_VALID  = 16'hF1FF;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic             input_dir;
        logic [SEL_W-1:0] sel;
    } pin_cfg_t;

    typedef struct packed {
        logic             strobe;
        logic             func_sel;
        logic             read_write;
        logic [BUS_W-1:0] bus;
    } port_in_t;

    localparam int PORT_IN_W = BUS_W + 3;

    typedef enum logic [0:0] {
        PH_ADDR = 1'b0,
        PH_DATA = 1'b1
    } phase_t;

    // ------------------------------------------------------------
    // power-on pin functions, pin 0 in the low six bits
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] RST_PIN0 = 6'h12;
    localparam logic [CODE_W-1:0] RST_PIN1 = 6'h13;
    localparam logic [CODE_W-1:0] RST_PIN2 = 6'h14;
    localparam logic [CODE_W-1:0] RST_PIN3 = 6'h19;
    localparam logic [CODE_W-1:0] RST_PIN4 = 6'h1C;
    localparam logic [CODE_W-1:0] RST_PIN5 = 6'h04;
    localparam logic [CODE_W-1:0] RST_PIN6 = 6'h1B;
    localparam logic [CODE_W-1:0] RST_PIN7 = 6'h0E;
    localparam logic [NUM_PINS*CODE_W-1:0] RST_ALL = {
        RST_PIN7, RST_PIN6, RST_PIN5, RST_PIN4,
        RST_PIN3, RST_PIN2, RST_PIN1, RST_PIN0
    };

endpackage

// *** core/port_sync.sv ***
// two-flop synchroniser for the asynchronous port pins
module port_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (W < 1)
    begin : g_chk
        $error("port_sync width must be at least one");
    end

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    // first stage is read by the second stage only
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end

endmodule // port_sync

// *** dv/host_port_model.sv ***
// host controller model that programs the pin mapper over the control port
module host_port_model (
    input  wire logic                                     clk,
    output logic                                          port_strobe,
    output logic                                          port_function_select,
    output logic                                          port_read_write,
    output logic      [io_port_bit_mapper_pkg::BUS_W-1:0] port_bus_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    // inputs have pull-downs, so a released pin reads low
    initial
    begin
        port_strobe          = 1'b0;
        port_function_select = 1'b0;
        port_read_write      = 1'b0;
        port_bus_in          = '0;
    end

    // ------------------------------------------------------------
    // one strobe cycle, 550 ns; slow adds set-up cycles
    // ------------------------------------------------------------
    task automatic xfer(input logic [io_port_bit_mapper_pkg::BUS_W-1:0] word,
                        input logic sel, input logic rw, input int slow);
        @(negedge clk);
        port_function_select = sel;
        port_read_write      = rw;
        port_bus_in          = word;
        repeat (2 + slow) @(negedge clk);
        port_strobe = 1'b1;
        repeat (4) @(negedge clk);
        port_strobe = 1'b0;
        repeat (4) @(negedge clk);
        // hold time over: bus goes to the pull-down level
        port_bus_in          = '0;
        port_function_select = 1'b0;
        port_read_write      = 1'b0;
    endtask

    // address phase then data phase; code carries its own direction bit
    task automatic write_reg(input logic [io_port_bit_mapper_pkg::BUS_W-1:0] addr,
                             input logic [5:0] code, input int slow);
        xfer(addr, 1'b0, 1'b0, slow);
        xfer({4'hC, code}, 1'b0, 1'b0, slow);
    endtask
endmodule // host_port_model

// *** dv/io_port_bit_mapper_tb.sv ***
// self-checking testbench of the port pin mapper
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module io_port_bit_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        strobe;
    logic        fsel;
    logic        rw;
    logic [9:0]  bus;
    logic [7:0]  ext_pin = 8'h00;
    logic [7:0]  pin_in;
    logic [31:0] status = 32'h0;
    logic [15:0] ctrl = 16'h0;
    logic [7:0]  pin_out;
    logic [7:0]  oe_n;
    logic [15:0] cbits;
    logic [15:0] covr;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [5:0]  dflt [8] = '{6'h12, 6'h13, 6'h14, 6'h19, 6'h1C, 6'h04, 6'h1B, 6'h0E};
    logic [5:0]  cfg [8];

    always #25 clk = ~clk;

    // pin level: the device drives where enabled, else the outside world
    assign pin_in = (~oe_n & pin_out) | (oe_n & ext_pin);

    host_port_model host (
        .clk                  (clk),
        .port_strobe          (strobe),
        .port_function_select (fsel),
        .port_read_write      (rw),
        .port_bus_in          (bus)
    );

    io_port_bit_mapper #(.NUM_PINS(8)) dut (
        .clk                  (clk),
        .rst                  (rst),
        .port_strobe          (strobe),
        .port_function_select (fsel),
        .port_read_write      (rw),
        .port_bus_in          (bus),
        .io_pin_in            (pin_in),
        .status_bits          (status),
        .ctrl_reg_value       (ctrl),
        .io_pin_out           (pin_out),
        .io_pin_oe_n          (oe_n),
        .control_bits         (cbits),
        .control_override     (covr)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic bit out_ok(input logic [5:0] c);
        return !(c == 6'h00 || c == 6'h05 || c == 6'h06 || (c >= 6'h0A && c <= 6'h0C));
    endfunction

    // drives pattern and its inverse so a stuck pin cannot match twice
    task automatic check_outs(input logic [31:0] p);
        for (int k = 0; k < 2; k++)
        begin
            status = k ? ~p : p;
            repeat (2) @(negedge clk);
            for (int i = 0; i < 8; i++)
            begin
                `CHK(oe_n[i], cfg[i][5])
                if (!cfg[i][5])
                    `CHK(pin_out[i], out_ok(cfg[i]) ? status[cfg[i][4:0]] : 1'b0)
            end
        end
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        cfg = dflt;
        repeat (3) @(negedge clk);
        check_outs(32'h6A3C_95E1);
        $display("test reset defaults done");
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("BAD t=%0t run did not finish", $time);
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        do_reset();
        // every register address, prompt and slow host
        for (int i = 0; i < 8; i++)
        begin
            host.write_reg(10'h00F + 10'(i), 6'h10 + 6'(i), i % 2);
            cfg[i] = 6'h10 + 6'(i);
        end
        check_outs(32'h00A5_3C00);
        // addresses either side of the block are dropped
        host.write_reg(10'h017, 6'h01, 0);
        host.write_reg(10'h00E, 6'h01, 0);
        // ancillary and read strobes restart the address phase
        host.xfer(10'h010, 1'b0, 1'b0, 0);
        host.xfer(10'h001, 1'b1, 1'b0, 0);
        host.xfer(10'h011, 1'b0, 1'b1, 0);
        host.write_reg(10'h011, 6'h01, 0);
        cfg[2] = 6'h01;
        check_outs(32'h00A5_3C02);
        $display("test addressing done");
        // every output code on the last pin
        for (int c = 0; c < 32; c++)
        begin
            host.write_reg(10'h016, 6'(c), 0);
            cfg[7] = 6'(c);
            check_outs(32'h1 << c);
        end
        $display("test output codes done");
        // every input code 20h-2Fh on pin 0
        for (int j = 0; j < 16; j++)
        begin
            host.write_reg(10'h00F, 6'h20 + 6'(j), 0);
            cfg[0] = 6'h20 + 6'(j);
            ctrl       = 16'h0000;
            ext_pin[0] = 1'b1;
            repeat (5) @(negedge clk);
            `CHK(oe_n[0], 1'b1)
            `CHK(covr, (j >= 9 && j <= 11) ? 16'h0 : 16'h1 << j)
            `CHK(cbits, (j >= 9 && j <= 11) ? 16'h0 : 16'h1 << j)
            ext_pin[0] = 1'b0;
            ctrl       = 16'hFFFF;
            repeat (5) @(negedge clk);
            `CHK(cbits, (j >= 9 && j <= 11) ? 16'hFFFF : ~(16'h1 << j))
        end
        // input codes above 2Fh give no override; pin 7 then takes control bit 0
        ctrl       = 16'h0000;
        ext_pin[7] = 1'b1;
        host.write_reg(10'h016, 6'h30, 0);
        cfg[7] = 6'h30;
        repeat (5) @(negedge clk);
        `CHK(covr, 16'h8000)
        `CHK(cbits, 16'h0000)
        host.write_reg(10'h016, 6'h20, 0);
        cfg[7] = 6'h20;
        repeat (5) @(negedge clk);
        `CHK(covr, 16'h8001)
        `CHK(cbits, 16'h0001)
        ext_pin[7] = 1'b0;
        check_outs(32'h5C3A_E196);
        $display("test input codes done");
        do_reset();
        stop_test();
    end
endmodule // io_port_bit_mapper_tb
